// >>> logic/rate_compare_regs.svh
`ifndef RATE_COMPARE_REGS_SVH
`define RATE_COMPARE_REGS_SVH

`define ADDR_W 4
`define BUF_DEPTH 16
`define RD_CLEAR_VAL 4'h0
`define WR_PRESET_VAL 4'hA
`define STUFF_NOMINAL 4'h8
`define STUFF_SPAN 4'h2
`define DRIFT_TOL_PPM 250
`define CORE_CLK_MHZ 10
`define TIMING_TIMEOUT_US 50000
`define ENABLE_TIMEOUT_US 500000
`define ACT_CNT_W 23
`define ACT_CHANNELS 2

`endif

// >>> logic/rate_compare_pkg.sv
`default_nettype none
package rate_compare_pkg;
	typedef enum logic [1:0] {
		STUFF_NONE = 2'b00,
		STUFF_POS = 2'b01,
		STUFF_NEG = 2'b10,
		STUFF_OOT = 2'b11
	} stuff_cmd_e;

	typedef enum logic [1:0] {
		INIT_IDLE = 2'b00,
		INIT_CLR_RD = 2'b01,
		INIT_WAIT = 2'b10,
		INIT_PRESET = 2'b11
	} init_state_e;
endpackage
`default_nettype wire

// >>> logic/pin_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o,
	output logic [WIDTH-1:0] rise_o
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] level_d;

	// A bit only moves once the second and third stages agree.
	assign level_d = (s3_q & ~(s2_q ^ s3_q)) | (level_o & (s2_q ^ s3_q));

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			level_o <= '0;
			rise_o <= '0;
		end else begin
			level_o <= level_d;
			rise_o <= level_d & ~level_o;
		end
	end
endmodule
`default_nettype wire

// >>> logic/transition_coder.sv
`timescale 1ns/1ps
`default_nettype none
module transition_coder (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic data_i,
	input wire logic timing_level_i,
	input wire logic tick_i,
	output logic code_o
);
	logic seen_q;
	logic sampled_q;
	logic half_q;
	logic bit2_q;
	logic bit3_q;
	logic [1:0] phase_q;

	// The half is taken from the timing level at the moment the data moves.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			seen_q <= 1'b0;
			half_q <= 1'b0;
		end else begin
			seen_q <= data_i;
			if (data_i != seen_q)
				half_q <= timing_level_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sampled_q <= 1'b0;
			bit2_q <= 1'b0;
			bit3_q <= 1'b0;
			phase_q <= 2'h0;
			code_o <= 1'b0;
		end else if (tick_i) begin
			sampled_q <= data_i;
			if (phase_q == 2'h0 && data_i != sampled_q) begin
				code_o <= 1'b1;
				bit2_q <= half_q;
				bit3_q <= data_i;
				phase_q <= 2'h2;
			end else if (phase_q == 2'h2) begin
				code_o <= bit2_q;
				phase_q <= 2'h1;
			end else if (phase_q == 2'h1) begin
				code_o <= bit3_q;
				phase_q <= 2'h0;
			end else begin
				code_o <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> logic/elastic_buffer_rate_compare_diag.sv
// Functional notes
// - Absorb up to 250 ppm drift by detecting rate difference and compensating.
// - At word 24 bit 0 latch read address and raise load enable.
// - With load enable set, latch write address on next channel timing pulse.
// - Out-of-tolerance suppresses the read latch load and the load enable.
// - Difference is latched read address minus latched write address, four bits.
// - Offset above nominal gives positive stuff; below nominal gives negative stuff.
// - Offset beyond stuffing reach gives out-of-tolerance; an offset of exactly nominal gives nothing.
// - Out-of-tolerance restarts initialisation, which clears the read counter to zero.
// - Two clocks after the clear, preset write counter to ten, during word 24.
// - Keep nominal eight-count separation so read and write never share a cell.
// - Negative stuff command drives the active-low negative stuff request.
// - Word 24 puts card status on positive stuff line; else positive stuff.
// - Transition-encoding mode feeds a duplicate 3-bit code into diagnostic buffer.
// - Timing-recovery mode feeds second receiver data into diagnostic buffer.
// - Latched write equals live read with gated clock raises compare-enable.
// - On compare-enable, mismatched diagnostic and output bits flag an error.
// - Missing compare-enable pulses beyond the timeout flag an error.
// - Missing channel timing pulses beyond the timeout flag an error.
// - Disagreeing data from the two receivers flags an error.
// - Card error is the OR of four errors, reported during word 24.
// - Read counter steps per gated read clock; write counter per timing pulse.
`timescale 1ns/1ps
`default_nettype none
`include "rate_compare_regs.svh"
module elastic_buffer_rate_compare_diag
	import rate_compare_pkg::*;
#(
	parameter int unsigned TIMING_TIMEOUT_CYC =
		`TIMING_TIMEOUT_US * `CORE_CLK_MHZ,
	parameter int unsigned ENABLE_TIMEOUT_CYC =
		`ENABLE_TIMEOUT_US * `CORE_CLK_MHZ
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic chan_timing_i,
	input wire logic rx_data_a_i,
	input wire logic rx_data_b_i,
	input wire logic transition_encoding_mode_i,
	input wire logic word24_i,
	input wire logic word24_bit0_i,
	input wire logic gated_read_clock_i,
	input wire logic system_read_clock_i,
	output logic neg_stuff_request_n_o,
	output logic pos_stuff_request_n_o,
	output logic card_error_o,
	output logic data_out_o,
	output logic [`ADDR_W-1:0] read_addr_o,
	output logic [`ADDR_W-1:0] write_addr_o
);
	localparam int unsigned MAX_CYC = (1 << `ACT_CNT_W) - 1;

	if (TIMING_TIMEOUT_CYC == 0 || TIMING_TIMEOUT_CYC > MAX_CYC)
		$error("Timing timeout does not fit the activity counter.");
	if (ENABLE_TIMEOUT_CYC == 0 || ENABLE_TIMEOUT_CYC > MAX_CYC)
		$error("Enable timeout does not fit the activity counter.");

	logic [3:0] pin_level;
	logic [3:0] pin_rise;
	logic timing_level;
	logic timing_tick;
	logic rx_a;
	logic rx_b;
	logic te_mode;
	logic main_code;
	logic dup_code;

	logic [`ADDR_W-1:0] rd_q;
	logic [`ADDR_W-1:0] wr_q;
	logic [`ADDR_W-1:0] rd_latch_q;
	logic [`ADDR_W-1:0] wr_latch_q;
	logic [`ADDR_W-1:0] hold_addr_q;
	logic [`ADDR_W-1:0] diff;
	logic load_en_q;
	logic decode_go_q;
	stuff_cmd_e cmd_q;
	stuff_cmd_e cmd_d;
	logic oot_q;
	init_state_e init_q;

	logic [`BUF_DEPTH-1:0] main_mem_q;
	logic [`BUF_DEPTH-1:0] diag_mem_q;
	logic main_bit;
	logic diag_bit;
	logic gated_seen_q;
	logic cmp_en_q;
	logic cmp_pend_q;
	logic cmp_main_q;
	logic cmp_diag_q;
	logic data_err_q;
	logic rx_mis_q;
	logic [`ACT_CHANNELS-1:0] act_err;
	logic card_err_d;

	pin_sync3 #(
		.WIDTH(4)
	) u_sync (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.pin_i({transition_encoding_mode_i, rx_data_b_i, rx_data_a_i,
			chan_timing_i}),
		.level_o(pin_level),
		.rise_o(pin_rise)
	);

	assign timing_level = pin_level[0];
	assign timing_tick = pin_rise[0];
	assign rx_a = pin_level[1];
	assign rx_b = pin_level[2];
	assign te_mode = pin_level[3];

	transition_coder u_main_coder (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.data_i(rx_a),
		.timing_level_i(timing_level),
		.tick_i(timing_tick),
		.code_o(main_code)
	);

	// The duplicate coder sees the second receiver, so a receiver fault
	// shows up in the buffer compare as well as in the receiver compare.
	transition_coder u_dup_coder (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.data_i(rx_b),
		.timing_level_i(timing_level),
		.tick_i(timing_tick),
		.code_o(dup_code)
	);

	assign main_bit = te_mode ? main_code : rx_a;
	assign diag_bit = te_mode ? dup_code : rx_b;

	// Counters. Initialisation wins over a counting pulse in the same cycle.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_q <= `RD_CLEAR_VAL;
		end else if (init_q == INIT_CLR_RD) begin
			rd_q <= `RD_CLEAR_VAL;
		end else if (gated_read_clock_i) begin
			rd_q <= rd_q + 4'h1;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_q <= `WR_PRESET_VAL;
		end else if (init_q == INIT_PRESET) begin
			wr_q <= `WR_PRESET_VAL;
		end else if (timing_tick) begin
			wr_q <= wr_q + 4'h1;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			main_mem_q <= '0;
			diag_mem_q <= '0;
		end else if (timing_tick) begin
			main_mem_q[wr_q] <= main_bit;
			diag_mem_q[wr_q] <= diag_bit;
		end
	end

	// Rate compare latches.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_latch_q <= `RD_CLEAR_VAL;
			wr_latch_q <= `WR_PRESET_VAL;
			load_en_q <= 1'b0;
			decode_go_q <= 1'b0;
		end else begin
			decode_go_q <= 1'b0;
			if (word24_bit0_i && !oot_q) begin
				rd_latch_q <= rd_q;
				load_en_q <= 1'b1;
			end else if (load_en_q && oot_q) begin
				load_en_q <= 1'b0;
			end else if (load_en_q && timing_tick) begin
				wr_latch_q <= wr_q;
				load_en_q <= 1'b0;
				decode_go_q <= 1'b1;
			end
		end
	end

	assign diff = rd_latch_q - wr_latch_q;

	// The window of two counts either side of nominal covers the drift
	// between compares; anything wider means the slip cannot be stuffed out.
	always_comb begin
		cmd_d = STUFF_OOT;
		if (diff == `STUFF_NOMINAL)
			cmd_d = STUFF_NONE;
		else if (diff > `STUFF_NOMINAL &&
				diff <= `STUFF_NOMINAL + `STUFF_SPAN)
			cmd_d = STUFF_POS;
		else if (diff < `STUFF_NOMINAL &&
				diff >= `STUFF_NOMINAL - `STUFF_SPAN)
			cmd_d = STUFF_NEG;
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			cmd_q <= STUFF_NONE;
		else if (decode_go_q)
			cmd_q <= cmd_d;
		else if (init_q == INIT_PRESET)
			cmd_q <= STUFF_NONE;
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			oot_q <= 1'b0;
		else if (decode_go_q && cmd_d == STUFF_OOT)
			oot_q <= 1'b1;
		else if (init_q == INIT_PRESET)
			oot_q <= 1'b0;
	end

	// Initialisation starts only inside word 24, as does the read latch load.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			init_q <= INIT_IDLE;
		end else begin
			unique case (init_q)
				INIT_IDLE: begin
					if (oot_q && word24_i)
						init_q <= INIT_CLR_RD;
				end
				INIT_CLR_RD: init_q <= INIT_WAIT;
				INIT_WAIT: init_q <= INIT_PRESET;
				INIT_PRESET: init_q <= INIT_IDLE;
			endcase
		end
	end

	// Output buffer and compare enable on the system read clock.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hold_addr_q <= `RD_CLEAR_VAL;
			data_out_o <= 1'b0;
			gated_seen_q <= 1'b0;
			cmp_en_q <= 1'b0;
		end else begin
			cmp_en_q <= 1'b0;
			if (system_read_clock_i) begin
				hold_addr_q <= rd_q;
				data_out_o <= main_mem_q[hold_addr_q];
				gated_seen_q <= gated_read_clock_i;
				cmp_en_q <= (gated_seen_q || gated_read_clock_i) &&
					(wr_latch_q == rd_q);
			end else if (gated_read_clock_i) begin
				gated_seen_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmp_pend_q <= 1'b0;
			cmp_main_q <= 1'b0;
			cmp_diag_q <= 1'b0;
			data_err_q <= 1'b0;
		end else begin
			cmp_pend_q <= cmp_en_q;
			if (cmp_en_q) begin
				cmp_main_q <= main_mem_q[wr_latch_q];
				cmp_diag_q <= diag_mem_q[wr_latch_q];
			end
			if (cmp_pend_q)
				data_err_q <= cmp_main_q != cmp_diag_q;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			rx_mis_q <= 1'b0;
		else
			rx_mis_q <= rx_a != rx_b;
	end

	// Index 0 watches compare enables, index 1 watches timing pulses.
	for (genvar g = 0; g < `ACT_CHANNELS; g++) begin : g_act
		localparam int unsigned TMO =
			(g == 0) ? ENABLE_TIMEOUT_CYC : TIMING_TIMEOUT_CYC;
		logic [`ACT_CNT_W-1:0] cnt_q;
		logic reload;

		assign reload = (g == 0) ? cmp_en_q : timing_tick;

		always_ff @(posedge core_clk_i or negedge nrst_i) begin
			if (!nrst_i)
				cnt_q <= `ACT_CNT_W'(TMO);
			else if (reload)
				cnt_q <= `ACT_CNT_W'(TMO);
			else if (cnt_q != '0)
				cnt_q <= cnt_q - 1'b1;
		end

		assign act_err[g] = cnt_q == '0;
	end

	assign card_err_d = data_err_q | rx_mis_q | (|act_err);

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			card_error_o <= 1'b0;
			neg_stuff_request_n_o <= 1'b1;
			pos_stuff_request_n_o <= 1'b1;
		end else begin
			card_error_o <= card_err_d;
			neg_stuff_request_n_o <= cmd_q != STUFF_NEG;
			if (word24_i)
				pos_stuff_request_n_o <= !card_err_d;
			else
				pos_stuff_request_n_o <= cmd_q != STUFF_POS;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			read_addr_o <= `RD_CLEAR_VAL;
			write_addr_o <= `WR_PRESET_VAL;
		end else begin
			read_addr_o <= rd_q;
			write_addr_o <= wr_q;
		end
	end

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);

	rd_latch_load_a: assert property (
		word24_bit0_i && !oot_q |=> rd_latch_q == $past(rd_q) && load_en_q)
		else $error("Read latch not loaded at word 24 bit 0.");

	oot_inhibit_a: assert property (
		oot_q && !decode_go_q |=> $stable(rd_latch_q) && !load_en_q)
		else $error("Latch load while out of tolerance.");

	wr_latch_load_a: assert property (
		load_en_q && !oot_q && !word24_bit0_i && timing_tick
		|=> wr_latch_q == $past(wr_q) ##1 cmd_q == $past(cmd_d))
		else $error("Write latch or decode missed on timing pulse.");

	decode_pos_a: assert property (
		decode_go_q && diff == `STUFF_NOMINAL + 4'h1 |=> cmd_q == STUFF_POS
		##1 !pos_stuff_request_n_o || $past(word24_i))
		else $error("Positive stuff not decoded.");

	decode_none_a: assert property (
		decode_go_q && diff == `STUFF_NOMINAL |=> cmd_q == STUFF_NONE ##1
		neg_stuff_request_n_o)
		else $error("No-action decode produced a request.");

	neg_request_a: assert property (
		cmd_q == STUFF_NEG [*2] |-> !neg_stuff_request_n_o)
		else $error("Negative stuff request not asserted.");

	init_sequence_a: assert property (
		init_q == INIT_CLR_RD |=> rd_q == `RD_CLEAR_VAL ##2
		wr_q == `WR_PRESET_VAL && !oot_q)
		else $error("Initialisation clear or preset out of step.");

	oot_restart_a: assert property (
		oot_q && word24_i && init_q == INIT_IDLE |=> init_q == INIT_CLR_RD)
		else $error("Out of tolerance did not start initialisation.");

	word24_status_a: assert property (
		word24_i && $past(word24_i) |=> pos_stuff_request_n_o ==
		!$past(card_err_d))
		else $error("Positive stuff line not carrying card status.");

	rx_mismatch_a: assert property (
		rx_a != rx_b |-> ##2 card_error_o)
		else $error("Receiver mismatch not reported.");

	timing_watch_a: assert property (
		g_act[1].cnt_q == `ACT_CNT_W'(1) && !timing_tick |-> ##2 card_error_o)
		else $error("Timing activity timeout not reported.");
endmodule
`default_nettype wire

// >>> bench/frame_timing_model.sv
`timescale 1ns/1ps
`default_nettype none
module frame_timing_model (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic gate_load_i,
	input wire logic [4:0] gate_count_i,
	input wire logic frame_go_i,
	output logic word24_o,
	output logic word24_bit0_o,
	output logic gated_read_clock_o,
	output logic system_read_clock_o
);
	logic [2:0] slot_q;
	logic [4:0] gates_q;
	logic [3:0] word_q;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			slot_q <= 3'h0;
			system_read_clock_o <= 1'b0;
		end else begin
			slot_q <= slot_q + 3'h1;
			system_read_clock_o <= (slot_q == 3'h7);
		end
	end

	// Gated pulses ride on system read slots, so a budget gives an exact count.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			gates_q <= 5'h00;
			gated_read_clock_o <= 1'b0;
		end else if (gate_load_i) begin
			gates_q <= gate_count_i;
			gated_read_clock_o <= 1'b0;
		end else if (slot_q == 3'h7 && gates_q != 5'h00) begin
			gates_q <= gates_q - 5'h01;
			gated_read_clock_o <= 1'b1;
		end else begin
			gated_read_clock_o <= 1'b0;
		end
	end

	// Word 24 lasts sixteen cycles; bit 0 is its first cycle.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			word_q <= 4'h0;
			word24_o <= 1'b0;
			word24_bit0_o <= 1'b0;
		end else if (frame_go_i) begin
			word_q <= 4'hF;
			word24_o <= 1'b1;
			word24_bit0_o <= 1'b1;
		end else begin
			word24_bit0_o <= 1'b0;
			if (word_q != 4'h0) begin
				word_q <= word_q - 4'h1;
			end else begin
				word24_o <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
	import rate_compare_pkg::*;
;
	localparam int TT = 200;
	localparam int ET = 3000;
	logic core_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic chan_timing = 1'b0;
	logic rx_a = 1'b0;
	logic rx_b = 1'b0;
	logic flip = 1'b0;
	logic te_mode = 1'b0;
	logic gate_load = 1'b0;
	logic [4:0] gate_count = 5'h00;
	logic frame_go = 1'b0;
	logic word24, word24_bit0, gated_rd, sys_rd;
	logic neg_n, pos_n, card_error, data_out;
	logic [3:0] rd_addr, wr_addr;
	logic [31:0] seed = 32'h00000052;
	int errors = 0;
	int samples_checked = 0;
	logic [3:0] diffs [8] = '{4'h8, 4'h9, 4'hA, 4'h6, 4'h7, 4'h5, 4'hB, 4'h0};

	elastic_buffer_rate_compare_diag #(.TIMING_TIMEOUT_CYC(TT),
		.ENABLE_TIMEOUT_CYC(ET)) i_elastic_buffer_rate_compare_diag (
		.core_clk_i(core_clk_i), .nrst_i(nrst_i),
		.chan_timing_i(chan_timing), .rx_data_a_i(rx_a),
		.rx_data_b_i(rx_b), .transition_encoding_mode_i(te_mode),
		.word24_i(word24), .word24_bit0_i(word24_bit0),
		.gated_read_clock_i(gated_rd), .system_read_clock_i(sys_rd),
		.neg_stuff_request_n_o(neg_n), .pos_stuff_request_n_o(pos_n),
		.card_error_o(card_error), .data_out_o(data_out),
		.read_addr_o(rd_addr), .write_addr_o(wr_addr));

	frame_timing_model i_frame_timing_model (
		.core_clk_i(core_clk_i), .nrst_i(nrst_i),
		.gate_load_i(gate_load), .gate_count_i(gate_count),
		.frame_go_i(frame_go), .word24_o(word24),
		.word24_bit0_o(word24_bit0), .gated_read_clock_o(gated_rd),
		.system_read_clock_o(sys_rd));

	initial begin
		forever #50 core_clk_i = ~core_clk_i;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic stuff_cmd_e exp_cmd(input logic [3:0] d);
		if (d == 4'h8) return STUFF_NONE;
		if (d == 4'h9 || d == 4'hA) return STUFF_POS;
		if (d == 4'h6 || d == 4'h7) return STUFF_NEG;
		return STUFF_OOT;
	endfunction

	task automatic check_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
		end
	endtask

	task automatic check_addr(input logic [3:0] got, input logic [3:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: address %h, expected %h", $time,
				got, exp);
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	task automatic do_reset();
		nrst_i = 1'b0;
		wait_clk(16);
		nrst_i = 1'b1;
		wait_clk(4);
	endtask

	// The link clock stands still between bursts, as the far side does.
	task automatic send_timing(input int n);
		for (int i = 0; i < n; i++) begin
			rx_a = 1'(xs());
			rx_b = rx_a ^ flip;
			chan_timing = 1'b1;
			wait_clk(4);
			chan_timing = 1'b0;
			wait_clk(4);
		end
	endtask

	task automatic pulse_frame();
		frame_go = 1'b1;
		wait_clk(1);
		frame_go = 1'b0;
	endtask

	task automatic run_case(input logic [3:0] d);
		logic [3:0] m;
		logic [3:0] k;
		stuff_cmd_e e;
		m = 4'(xs());
		// The write latch takes the count from before the pulse that loads it.
		k = m - 4'hA - d;
		e = exp_cmd(d);
		do_reset();
		te_mode = 1'(xs());
		gate_count = {1'b0, m};
		gate_load = 1'b1;
		wait_clk(1);
		gate_load = 1'b0;
		wait_clk(8 * m + 10);
		send_timing(k);
		pulse_frame();
		wait_clk(2);
		send_timing(1);
		wait_clk(20);
		check_bit(neg_n, e != STUFF_NEG);
		check_bit(pos_n, e != STUFF_POS);
		pulse_frame();
		wait_clk(6);
		if (e == STUFF_OOT) begin
			check_addr(rd_addr, 4'h0);
			check_addr(wr_addr, 4'hA);
			wait_clk(20);
			check_bit(neg_n, 1'b1);
			check_bit(pos_n, 1'b1);
		end else begin
			check_bit(pos_n, 1'b1);
			check_addr(rd_addr, m);
			check_addr(wr_addr, 4'hB + k);
		end
		wait_clk(20);
	endtask

	task automatic stop_test();
		$display("comparisons %0d, errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#(100 * 40000);
		errors++;
		stop_test();
	end

	initial begin
		logic last_bit;
		wait_clk(2);
		check_bit(neg_n, 1'b1);
		check_bit(pos_n, 1'b1);
		check_bit(card_error, 1'b0);
		check_addr(wr_addr, 4'hA);
		foreach (diffs[i]) begin
			run_case(diffs[i]);
		end
		// A quiet link must be noticed, then forgiven on the next pulse.
		do_reset();
		wait_clk(TT + 20);
		check_bit(card_error, 1'b1);
		pulse_frame();
		wait_clk(3);
		check_bit(pos_n, 1'b0);
		send_timing(2);
		wait_clk(10);
		check_bit(card_error, 1'b0);
		do_reset();
		flip = 1'b1;
		send_timing(2);
		check_bit(card_error, 1'b1);
		flip = 1'b0;
		send_timing(2);
		check_bit(card_error, 1'b0);
		// A bad bit parked at the latched write address must trip its compare.
		te_mode = 1'b0;
		do_reset();
		flip = 1'b1;
		send_timing(1);
		flip = 1'b0;
		send_timing(1);
		last_bit = rx_a;
		gate_count = 5'h0B;
		gate_load = 1'b1;
		wait_clk(1);
		gate_load = 1'b0;
		wait_clk(8 * 11 + 30);
		check_bit(card_error, 1'b1);
		check_bit(data_out, last_bit);
		do_reset();
		send_timing(ET / 8 + 25);
		check_bit(card_error, 1'b1);
		stop_test();
	end
endmodule
`default_nettype wire
